// ===== hcs_pkg.sv
package hcs_pkg;

  // ----------------------------------------
  // control register layout
  // ----------------------------------------
  localparam int unsigned HCS_M_BIT = 0;
  localparam int unsigned HCS_A_BIT = 1;
  localparam int unsigned HCS_C_BIT = 2;
  localparam int unsigned HCS_BEN_BIT = 5;
  localparam int unsigned HCS_ITD_BIT = 7;
  localparam logic [31:0] HCS_CTRL_RW_MASK = 32'h000000A7;
  localparam logic [31:0] HCS_CTRL_ONES = 32'h00000018;
  localparam logic [31:0] HCS_CTRL_RESET = 32'h00000000;

  // ----------------------------------------
  // coprocessor access encoding
  // ----------------------------------------
  localparam logic [3:0] HCS_COPROC = 4'hF;
  localparam logic [2:0] HCS_OPC1 = 3'h4;
  localparam logic [2:0] HCS_OPC2 = 3'h0;
  localparam logic [3:0] HCS_CRN = 4'h1;
  localparam logic [3:0] HCS_CRM = 4'h0;
  localparam logic [3:0] HCS_SYN_CRN = 4'h5;
  localparam logic [3:0] HCS_SYN_CRM = 4'h2;
  localparam logic [1:0] HCS_EL1 = 2'h1;
  localparam logic [1:0] HCS_EL2 = 2'h2;

  // ----------------------------------------
  // syndrome layout and exception classes
  // ----------------------------------------
  localparam int unsigned HCS_EC_LSB = 26;
  localparam logic [15:0] HCS_RSTR_MASK = 16'hFC87;
  localparam logic [15:0] HCS_RSTR_PAT = 16'h4487;
  localparam logic [5:0] HCS_EC_UNKNOWN = 6'h00;
  localparam logic [5:0] HCS_EC_WAIT = 6'h01;
  localparam logic [5:0] HCS_EC_CP15 = 6'h03;
  localparam logic [5:0] HCS_EC_CP15_DBL = 6'h04;
  localparam logic [5:0] HCS_EC_CP14 = 6'h05;
  localparam logic [5:0] HCS_EC_LDST = 6'h06;
  localparam logic [5:0] HCS_EC_SIMD = 6'h07;
  localparam logic [5:0] HCS_EC_FPID = 6'h08;
  localparam logic [5:0] HCS_EC_CP14_DBL = 6'h0C;
  localparam logic [5:0] HCS_EC_ILLRET = 6'h0E;
  localparam logic [5:0] HCS_EC_SVC = 6'h11;
  localparam logic [5:0] HCS_EC_HVC = 6'h12;
  localparam logic [5:0] HCS_EC_PABT_LO = 6'h20;
  localparam logic [5:0] HCS_EC_PABT_SAME = 6'h21;
  localparam logic [5:0] HCS_EC_PCALIGN = 6'h22;
  localparam logic [5:0] HCS_EC_DABT_LO = 6'h24;
  localparam logic [5:0] HCS_EC_DABT_SAME = 6'h25;

  typedef enum logic [3:0] {
    HCS_EV_UNKNOWN, HCS_EV_WAIT, HCS_EV_CP15, HCS_EV_CP15_DBL, HCS_EV_CP14,
    HCS_EV_LDST, HCS_EV_SIMD, HCS_EV_FPID, HCS_EV_CP14_DBL, HCS_EV_ILLRET,
    HCS_EV_SVC, HCS_EV_HVC, HCS_EV_PABT, HCS_EV_PCALIGN, HCS_EV_DABT
  } hcs_event_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] el;
    logic [3:0] coproc;
    logic [2:0] opc1;
    logic [2:0] opc2;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [31:0] wdata;
  } hcs_sysreg_t;

  typedef struct packed {
    logic valid;
    hcs_event_t kind;
    logic lower_el;
    logic cond_pass;
    logic simd_absent;
    logic report_unknown;
    logic [24:0] detail;
  } hcs_exc_t;

  typedef struct packed {
    logic valid;
    logic at_el2;
    logic in_it;
    logic it_as_32;
    logic [15:0] hw;
    logic [15:0] hw2;
    logic is_barrier;
  } hcs_insn_t;

  typedef struct packed {
    logic valid;
    logic at_el2;
    logic exclusive;
    logic [31:0] addr;
    logic [2:0] size_log2;
  } hcs_mem_t;

endpackage

// ===== hcs_control_syndrome.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1 - it restriction undefines restricted patterns in blocks
// RULE2 - undefined lands on second half or pair
// RULE3 - absent it restriction reads zero, ignores writes
// RULE4 - barrier enable gates coprocessor barrier instructions
// RULE5 - absent barrier enable reads one, ignores writes
// RULE6 - bit two gates hypervisor data cacheability
// RULE7 - bit one enables alignment checks, abort
// RULE8 - clear bit one skips ordinary alignment checks
// RULE9 - exclusive and acquire release always checked
// RULE10 - bit zero enables protection unit
// RULE11 - coprocessor encoding reaches control register at el2
// RULE12 - group trap sends kernel accesses to hypervisor
// RULE13 - syndrome register is thirty-two bits wide
// RULE14 - syndrome top six bits hold class
// RULE15 - unknown and wait classes, failed waits ignored
// RULE16 - coprocessor fifteen and fourteen transfer classes
// RULE17 - load store, simd, fp read classes
// RULE18 - missing simd reports unknown class
// RULE19 - double read, illegal return, pc alignment
// RULE20 - supervisor and hypervisor call classes
// RULE21 - prefetch abort classes by level
// RULE22 - data abort classes by level
// RULE23 - software avoids reserved class values
// RULE24 - bit six zero, bits four three one
module hcs_control_syndrome import hcs_pkg::*; #(
  parameter bit HAS_ITD = 1'b1,
  parameter bit HAS_BEN = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire hcs_sysreg_t sysreg_i,
  input wire logic group1_trap_i,
  output logic [31:0] sysreg_rdata_o,
  output logic sysreg_ack_o,
  output logic sysreg_undef_o,
  output logic sysreg_trap_o,
  input wire hcs_exc_t exc_i,
  input wire hcs_insn_t insn_i,
  output logic insn_undef_o,
  input wire hcs_mem_t mem_i,
  output logic align_fault_o,
  output logic [31:0] hyp_exception_syndrome_o,
  output logic data_cacheable_o,
  output logic protection_unit_en_o
);

  // ----------------------------------------
  // register access decode
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] syn_q;
  logic [31:0] syn_d;
  logic [31:0] ctrl_view;
  logic [31:0] wmask;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic enc_common;
  logic hit;
  logic is_syn;
  logic any_hit;
  logic el2_ok;
  logic trap;
  logic ack_q;
  logic ack_d;
  logic undef_q;
  logic undef_d;
  logic trapo_q;
  logic trapo_d;
  logic cap_en;
  logic [5:0] cap_ec;
  logic sw_ctrl_wr;
  logic sw_syn_wr;
  logic sw_rd;

  // syndrome sits in a spare slot of the same space, so one compare serves both
  always_comb begin
    enc_common = sysreg_i.valid;
    if (sysreg_i.coproc != HCS_COPROC) begin
      enc_common = 1'b0;
    end
    if (sysreg_i.opc1 != HCS_OPC1) begin
      enc_common = 1'b0;
    end
    if (sysreg_i.opc2 != HCS_OPC2) begin
      enc_common = 1'b0;
    end
    hit = enc_common && sysreg_i.crn == HCS_CRN && sysreg_i.crm == HCS_CRM; // [RULE11]
    is_syn = enc_common && sysreg_i.crn == HCS_SYN_CRN && sysreg_i.crm == HCS_SYN_CRM;
    any_hit = hit || is_syn;
    el2_ok = sysreg_i.el == HCS_EL2; // [RULE11]
    // the group trap covers the control register group only
    trap = hit && sysreg_i.el == HCS_EL1 && group1_trap_i; // [RULE12]
    sw_ctrl_wr = hit && el2_ok && sysreg_i.write;
    sw_syn_wr = is_syn && el2_ok && sysreg_i.write;
    sw_rd = any_hit && el2_ok && !sysreg_i.write;
  end

  // ----------------------------------------
  // implemented bits and read view
  // ----------------------------------------
  always_comb begin
    wmask = HCS_CTRL_RW_MASK;
    if (!HAS_ITD) begin
      wmask[HCS_ITD_BIT] = 1'b0; // [RULE3]
    end
    if (!HAS_BEN) begin
      wmask[HCS_BEN_BIT] = 1'b0; // [RULE5]
    end
  end

  // fixed-one bits come from a constant, so no stored value can clear them
  for (genvar b = 0; b < $bits(ctrl_view); b++) begin : g_view
    assign ctrl_view[b] = (!HAS_BEN && b == HCS_BEN_BIT) ? 1'b1 // [RULE5]
      : ((ctrl_q[b] & wmask[b]) | HCS_CTRL_ONES[b]); // [RULE24]
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (sw_ctrl_wr) begin
      ctrl_d = sysreg_i.wdata & wmask; // [RULE3] [RULE5] [RULE24]
    end
  end

  // bits with an unknown reset still start at zero to keep simulation defined
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= HCS_CTRL_RESET; // [RULE6] [RULE10]
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------
  // syndrome capture
  // ----------------------------------------
  function automatic logic [5:0] ec_of(input hcs_exc_t e);
    logic [5:0] ec;
    ec = HCS_EC_UNKNOWN; // [RULE15]
    case (e.kind)
      HCS_EV_WAIT: begin
        ec = HCS_EC_WAIT; // [RULE15]
      end
      HCS_EV_CP15: begin
        ec = e.report_unknown ? HCS_EC_UNKNOWN : HCS_EC_CP15; // [RULE16]
      end
      HCS_EV_CP15_DBL: begin
        ec = e.report_unknown ? HCS_EC_UNKNOWN : HCS_EC_CP15_DBL; // [RULE16]
      end
      HCS_EV_CP14: begin
        ec = HCS_EC_CP14; // [RULE16]
      end
      HCS_EV_LDST: begin
        ec = HCS_EC_LDST; // [RULE17]
      end
      HCS_EV_SIMD: begin
        ec = e.simd_absent ? HCS_EC_UNKNOWN : HCS_EC_SIMD; // [RULE17] [RULE18]
      end
      HCS_EV_FPID: begin
        ec = HCS_EC_FPID; // [RULE17]
      end
      HCS_EV_CP14_DBL: begin
        ec = HCS_EC_CP14_DBL; // [RULE19]
      end
      HCS_EV_ILLRET: begin
        ec = HCS_EC_ILLRET; // [RULE19]
      end
      HCS_EV_PCALIGN: begin
        ec = HCS_EC_PCALIGN; // [RULE19]
      end
      HCS_EV_SVC: begin
        ec = HCS_EC_SVC; // [RULE20]
      end
      HCS_EV_HVC: begin
        ec = HCS_EC_HVC; // [RULE20]
      end
      HCS_EV_PABT: begin
        ec = e.lower_el ? HCS_EC_PABT_LO : HCS_EC_PABT_SAME; // [RULE21]
      end
      HCS_EV_DABT: begin
        ec = e.lower_el ? HCS_EC_DABT_LO : HCS_EC_DABT_SAME; // [RULE22]
      end
      default: begin
        ec = HCS_EC_UNKNOWN;
      end
    endcase
    return ec;
  endfunction

  always_comb begin
    cap_en = exc_i.valid;
    if (exc_i.kind == HCS_EV_WAIT && !exc_i.cond_pass) begin
      cap_en = 1'b0; // [RULE15]
    end
    cap_ec = ec_of(exc_i); // [RULE14]
  end

  always_comb begin
    syn_d = syn_q;
    if (sw_syn_wr) begin
      syn_d = sysreg_i.wdata; // [RULE13]
    end
    // hardware capture wins over a software write in the same cycle
    if (cap_en) begin
      syn_d = {cap_ec, 1'b1, exc_i.detail}; // [RULE14]
    end
  end

  // syndrome reset is a defined zero although software may not rely on it
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      syn_q <= 32'h00000000;
    end else begin
      syn_q <= syn_d;
    end
  end

  // ----------------------------------------
  // access response
  // ----------------------------------------
  always_comb begin
    ack_d = any_hit && el2_ok; // [RULE11]
    undef_d = any_hit && !el2_ok && !trap; // [RULE11]
    trapo_d = trap; // [RULE12]
    rdata_d = rdata_q;
    if (sw_rd) begin
      if (hit) begin
        rdata_d = ctrl_view;
      end else begin
        rdata_d = syn_q;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
      undef_q <= 1'b0;
      trapo_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      undef_q <= undef_d;
      trapo_q <= trapo_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // instruction checks
  // ----------------------------------------
  logic it_block_restrict;
  logic ben;
  logic restricted;
  logic [15:0] pick_hw;
  logic [2:0] lowmask;
  logic misaligned;
  logic plain_chk;

  always_comb begin
    it_block_restrict = ctrl_view[HCS_ITD_BIT];
    ben = ctrl_view[HCS_BEN_BIT];
    // the pair view judges the second half, where the undefined result lands
    if (insn_i.it_as_32) begin
      pick_hw = insn_i.hw2; // [RULE2]
    end else begin
      pick_hw = insn_i.hw;
    end
    restricted = (pick_hw & HCS_RSTR_MASK) == HCS_RSTR_PAT; // [RULE1]
    insn_undef_o = 1'b0;
    if (insn_i.valid && insn_i.at_el2) begin
      if (it_block_restrict && insn_i.in_it && restricted) begin
        insn_undef_o = 1'b1; // [RULE1] [RULE2]
      end
      if (insn_i.is_barrier && !ben) begin
        insn_undef_o = 1'b1; // [RULE4]
      end
    end
  end

  // ----------------------------------------
  // memory checks
  // ----------------------------------------
  // elements wider than eight bytes are only checked on their low three bits
  always_comb begin
    case (mem_i.size_log2)
      3'h0: begin
        lowmask = 3'h0;
      end
      3'h1: begin
        lowmask = 3'h1;
      end
      3'h2: begin
        lowmask = 3'h3;
      end
      default: begin
        lowmask = 3'h7;
      end
    endcase
    misaligned = |(mem_i.addr[2:0] & lowmask);
    // exclusive and acquire/release ignore both the enable and the level
    plain_chk = mem_i.at_el2 && ctrl_view[HCS_A_BIT]; // [RULE7] [RULE8]
    align_fault_o = mem_i.valid && misaligned && (mem_i.exclusive || plain_chk); // [RULE9]
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sysreg_rdata_o = rdata_q;
  assign sysreg_ack_o = ack_q;
  assign sysreg_undef_o = undef_q;
  assign sysreg_trap_o = trapo_q;
  assign hyp_exception_syndrome_o = syn_q; // [RULE13]
  assign data_cacheable_o = ctrl_view[HCS_C_BIT]; // [RULE6]
  assign protection_unit_en_o = ctrl_view[HCS_M_BIT]; // [RULE10]

endmodule

// ===== hcs_checker.sv
`timescale 1ns/1ps
module hcs_checker import hcs_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire hcs_sysreg_t sysreg_i,
  input wire logic group1_trap_i,
  input wire logic [31:0] sysreg_rdata_o,
  input wire logic sysreg_ack_o,
  input wire logic sysreg_undef_o,
  input wire logic sysreg_trap_o,
  input wire hcs_exc_t exc_i,
  input wire hcs_mem_t mem_i,
  input wire logic align_fault_o,
  input wire logic [31:0] hyp_exception_syndrome_o
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  logic hit;
  logic [5:0] ec;
  assign hit = sysreg_i.valid && sysreg_i.coproc == HCS_COPROC && sysreg_i.opc1 == HCS_OPC1
    && sysreg_i.opc2 == HCS_OPC2 && sysreg_i.crn == HCS_CRN && sysreg_i.crm == HCS_CRM;
  assign ec = hyp_exception_syndrome_o[31:26];
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  a_ack_at_el2: assert property (hit && sysreg_i.el == HCS_EL2 |=> sysreg_ack_o)
    else $error("el2 access not acked");
  a_el1_trap: assert property (hit && sysreg_i.el == HCS_EL1 && group1_trap_i
    |=> sysreg_trap_o && !sysreg_ack_o) else $error("el1 access not trapped");
  a_el1_undef: assert property (hit && sysreg_i.el == HCS_EL1 && !group1_trap_i
    |=> sysreg_undef_o && !sysreg_ack_o) else $error("el1 access not refused");
  a_fixed_bits: assert property (hit && sysreg_i.el == HCS_EL2 && !sysreg_i.write
    |=> sysreg_rdata_o[4:3] == 2'h3 && !sysreg_rdata_o[6]) else $error("fixed bits wrong");
  a_svc_class: assert property (exc_i.valid && exc_i.kind == HCS_EV_SVC
    |=> ec == HCS_EC_SVC) else $error("svc class wrong");
  a_wait_fail: assert property (exc_i.valid && exc_i.kind == HCS_EV_WAIT && !exc_i.cond_pass
    |=> $stable(hyp_exception_syndrome_o)) else $error("failed wait captured");
  a_simd_gone: assert property (exc_i.valid && exc_i.kind == HCS_EV_SIMD && exc_i.simd_absent
    |=> ec == HCS_EC_UNKNOWN) else $error("absent simd class wrong");
  a_excl_align: assert property (mem_i.valid && mem_i.exclusive && mem_i.addr[0]
    && mem_i.size_log2 == 3'h1 |-> align_fault_o) else $error("exclusive misalign missed");
endmodule
bind hcs_control_syndrome hcs_checker u_chk (.*);

// ===== hcs_control_syndrome_tb.sv
`timescale 1ns/1ps
module hcs_control_syndrome_tb import hcs_pkg::*;;
  logic ref_clk_i = 0;
  logic resetn_i = 0;
  logic g1 = 0;
  hcs_sysreg_t sr = '0;
  hcs_exc_t ex = '0;
  hcs_insn_t ins = '0;
  hcs_mem_t mm = '0;
  logic [31:0] rd;
  logic [31:0] syn;
  logic ack, und, trp, iu, af, dc, pu;
  int n_fail = 0;
  int compares = 0;
  logic [5:0] ecs [15] = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
    6'h0C, 6'h0E, 6'h11, 6'h12, 6'h20, 6'h22, 6'h24};
  hcs_control_syndrome DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sysreg_i(sr),
    .group1_trap_i(g1), .sysreg_rdata_o(rd), .sysreg_ack_o(ack), .sysreg_undef_o(und),
    .sysreg_trap_o(trp), .exc_i(ex), .insn_i(ins), .insn_undef_o(iu), .mem_i(mm),
    .align_fault_o(af), .hyp_exception_syndrome_o(syn), .data_cacheable_o(dc),
    .protection_unit_en_o(pu));
  initial forever #2 ref_clk_i = ~ref_clk_i;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one request held for a single cycle, registered answer sampled just after that cycle ends
  task automatic acc(logic w, logic [1:0] el, logic g, logic [31:0] d);
    @(posedge ref_clk_i);
    g1 <= g;
    sr <= '{1'b1, w, el, HCS_COPROC, HCS_OPC1, HCS_OPC2, HCS_CRN, HCS_CRM, d};
    @(posedge ref_clk_i);
    sr.valid <= 1'b0;
    #1;
  endtask
  task automatic ev(hcs_event_t k, logic lo, logic cp, logic sa, logic [31:0] e);
    @(posedge ref_clk_i);
    ex <= '{1'b1, k, lo, cp, sa, 1'b0, 25'h1ABCDE};
    @(posedge ref_clk_i);
    ex.valid <= 1'b0;
    #1;
    chk("syndrome", e, syn);
  endtask
  // misaligned halfword access at el2 beside each instruction
  task automatic op(logic [15:0] h, logic t, logic br, logic x, logic ei, logic ea);
    @(posedge ref_clk_i);
    ins <= '{1'b1, 1'b1, 1'b1, t, t ? 16'h0000 : h, h, br};
    mm <= '{1'b1, 1'b1, x, 32'h00000001, 3'h1};
    #1;
    chk("insn_undef", ei, iu);
    chk("align_fault", ea, af);
  endtask
  task automatic t_regs();
    acc(0, HCS_EL2, 0, 0);
    chk("ack", 1, ack);
    chk("ctrl reset", 32'h00000018, rd);
    chk("cacheable", 0, dc);
    chk("pu", 0, pu);
    chk("syn reset", 0, syn);
    acc(1, HCS_EL2, 0, 32'hFFFFFFFF);
    acc(0, HCS_EL2, 0, 0);
    chk("ctrl rw", 32'h000000BF, rd);
    chk("cacheable", 1, dc);
    chk("pu", 1, pu);
    acc(0, HCS_EL1, 1, 0);
    chk("trap", 1, trp);
    acc(0, HCS_EL1, 0, 0);
    chk("undef", {1'b0, 1'b1}, {ack, und});
    $display("t_regs done");
  endtask
  task automatic t_syn();
    @(posedge ref_clk_i);
    sr <= '{1'b1, 1'b1, HCS_EL2, HCS_COPROC, HCS_OPC1, HCS_OPC2, HCS_SYN_CRN, HCS_SYN_CRM,
      32'h12345678};
    @(posedge ref_clk_i);
    sr.write <= 1'b0;
    @(posedge ref_clk_i);
    sr.valid <= 1'b0;
    #1;
    chk("syn rw", 32'h12345678, rd);
    chk("syn out", 32'h12345678, syn);
    $display("t_syn done");
  endtask
  task automatic t_insn();
    op(16'h4487, 0, 0, 0, 1, 1);
    op(16'h4487, 1, 0, 1, 1, 1);
    op(16'h0000, 0, 1, 0, 0, 1);
    acc(1, HCS_EL2, 0, 0);
    op(16'h0000, 0, 1, 0, 1, 0);
    op(16'h4487, 0, 0, 1, 0, 1);
    ins.valid <= 1'b0;
    mm.valid <= 1'b0;
    $display("t_insn done");
  endtask
  task automatic t_exc();
    for (int i = 0; i < 15; i++) begin // only defined classes are produced
      ev(hcs_event_t'(i), 1, 1, 0, {ecs[i], 1'b1, 25'h1ABCDE});
    end
    ev(HCS_EV_PABT, 0, 1, 0, {6'h21, 1'b1, 25'h1ABCDE});
    ev(HCS_EV_DABT, 0, 1, 0, {6'h25, 1'b1, 25'h1ABCDE});
    ev(HCS_EV_SIMD, 1, 1, 1, {6'h00, 1'b1, 25'h1ABCDE});
    ev(HCS_EV_WAIT, 1, 0, 0, {6'h00, 1'b1, 25'h1ABCDE});
    $display("t_exc done");
  endtask
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    results();
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_syn();
    t_insn();
    t_exc();
    results();
  end
endmodule
